// File: rtl/bwp_pkg.sv
// constants, carrier types and states of the byte/word packet packer
package bwp_pkg;

    // ---------------------------------------------------------------
    // widths
    // ---------------------------------------------------------------
    localparam int RAW = 4;
    localparam int DW = 16;
    localparam int LW = 12;

    // ---------------------------------------------------------------
    // register offsets
    // ---------------------------------------------------------------
    localparam logic [RAW-1:0] REG_CTRL = 4'h0;
    localparam logic [RAW-1:0] REG_LEN = 4'h1;
    localparam logic [RAW-1:0] REG_BASE = 4'h2;
    localparam logic [RAW-1:0] REG_STAT = 4'h3;
    localparam logic [RAW-1:0] REG_CNT = 4'h4;

    // control and status bit positions
    localparam int CTL_START = 0;
    localparam int CTL_RX = 1;
    localparam int CTL_SWAP = 4;
    localparam int ST_BUSY = 0;
    localparam int ST_DONE = 1;
    localparam int ST_ERR = 2;

    // ---------------------------------------------------------------
    // length limits, reset values, fill values
    // ---------------------------------------------------------------
    localparam logic [LW-1:0] LEN_MIN = 12'h001;
    localparam logic [LW-1:0] LEN_MAX = 12'h800;
    localparam logic [LW-1:0] LEN_RST = 12'h001;
    localparam logic [DW-1:0] BASE_RST = 16'h0000;
    localparam logic [DW-1:0] HDR_OFS = 16'h0001;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [3:0] LEN_PAD = 4'h0;

    // transfer mode, bits 4..1 of the control register
    typedef struct packed {
        logic swap;
        logic low_only;
        logic var_len;
        logic rx;
    } bwp_mode_t;

    // one byte on the serial stream
    typedef struct packed {
        logic last;
        logic [7:0] data;
    } bwp_byte_t;

    typedef enum {
        S_IDLE, S_WT, S_CAP, S_RD, S_TX0, S_TX1, S_RX, S_LENWR
    } bwp_state_t;

endpackage : bwp_pkg

// File: rtl/bwp_packer.sv
// byte/word packet packer: serial byte stream to and from 16-bit word storage
//
// Function
// - fixed data starts exactly at the configured base word, no header.
// - fixed two-byte mode occupies half as many words as bytes, rounded up.
// - fixed send, odd length: drop last upper byte, lower when swapped.
// - fixed receive, odd length: unused byte of last word is zero.
// - fixed low-byte mode occupies one word per data byte.
// - variable data: base word holds length, data starts at base plus one.
// - variable two-byte mode occupies length word plus half as many words as bytes, rounded up.
// - variable send, odd length: last upper byte not sent, lower when swapped.
// - variable receive, odd length: zero byte completes the last word.
// - variable low-byte mode occupies length word plus one word per byte.
// - all lengths, length word included, count bytes.
// - configured length or maximum accepted only from 1 to 2048.
// - two-byte mode without swap sends lower byte then upper byte.
// - low-byte mode sends only lower bytes, upper ignored.
// - low-byte mode stores byte in lower half, upper half cleared.
module bwp_packer
    import bwp_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [RAW-1:0] reg_addr,
    input wire logic [DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DW-1:0] reg_rdata,
    output logic [DW-1:0] mem_addr,
    output logic [DW-1:0] mem_wdata,
    output logic mem_we,
    output logic mem_re,
    input wire logic [DW-1:0] mem_rdata,
    output bwp_byte_t tx_byte,
    output logic tx_valid,
    input wire logic tx_ready,
    input wire bwp_byte_t rx_byte,
    input wire logic rx_valid,
    output logic rx_ready
);

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    bwp_state_t state_r;
    bwp_mode_t mode_r;
    logic [LW-1:0] len_r;
    logic [DW-1:0] base_r;
    logic [LW-1:0] cnt_r;
    logic [LW-1:0] xlen_r;
    logic hdr_r;
    logic [DW-1:0] word_r;
    logic [7:0] hold_r;
    logic busy_r, done_r, err_r;
    logic [DW-1:0] rdata_r, mem_addr_r, mem_wdata_r;
    logic mem_we_r, mem_re_r, rx_ready_r;
    bwp_byte_t tx_byte_r, skid_d_r;
    logic tx_valid_r, skid_v_r;

    logic start;
    logic [LW-1:0] cnt_inc;
    logic last_b, rx_take, rx_fin, rx_full;
    logic [LW-1:0] idx;
    logic [DW-1:0] data_addr;
    logic [DW-1:0] rx_word;
    logic [7:0] b0, b1;
    logic push_v;
    bwp_byte_t push_d;
    bwp_mode_t start_mode;

    // start only while idle; settings stay frozen during a transfer
    assign start = reg_wr && reg_addr == REG_CTRL && reg_wdata[CTL_START] && !busy_r;
    // mode_r is loaded on the same edge as start, so steer the first step from the bus word
    assign start_mode = bwp_mode_t'(reg_wdata[CTL_SWAP:CTL_RX]);
    assign cnt_inc = cnt_r + LEN_MIN;
    assign last_b = cnt_inc == xlen_r;

    // ---------------------------------------------------------------
    // storage addressing
    // ---------------------------------------------------------------
    // one word per byte in low-byte mode
    assign idx = mode_r.low_only ? cnt_r : {1'b0, cnt_r[LW-1:1]};
    // data from base, or base plus one after the length word
    assign data_addr = base_r + {LEN_PAD, idx} + (mode_r.var_len ? HDR_OFS : BASE_RST);

    // ---------------------------------------------------------------
    // byte selection for sending
    // ---------------------------------------------------------------
    // lower byte first, upper first only when swapped
    assign b0 = (mode_r.swap && !mode_r.low_only) ? word_r[15:8] : word_r[7:0];
    assign b1 = mode_r.swap ? word_r[7:0] : word_r[15:8];
    assign push_v = (state_r == S_TX0 || state_r == S_TX1) && !skid_v_r;
    assign push_d = '{last: last_b, data: (state_r == S_TX1) ? b1 : b0};

    // ---------------------------------------------------------------
    // word assembly for receiving
    // ---------------------------------------------------------------
    assign rx_take = rx_valid && rx_ready_r;
    assign rx_fin = last_b || (mode_r.var_len && rx_byte.last);
    assign rx_full = mode_r.low_only || cnt_r[0] || rx_fin;
    // unused half of a stored word reads zero
    always_comb begin
        if (mode_r.low_only) begin
            rx_word = {ZERO_BYTE, rx_byte.data};
        end else if (cnt_r[0]) begin
            rx_word = mode_r.swap ? {hold_r, rx_byte.data} : {rx_byte.data, hold_r};
        end else begin
            rx_word = mode_r.swap ? {rx_byte.data, ZERO_BYTE} : {ZERO_BYTE, rx_byte.data};
        end
    end

    // configuration registers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mode_r <= '0;
            len_r <= LEN_RST;
            base_r <= BASE_RST;
        end else if (reg_wr && !busy_r) begin
            if (reg_addr == REG_CTRL) begin
                mode_r <= bwp_mode_t'(reg_wdata[CTL_SWAP:CTL_RX]);
            end
            // out-of-range length leaves the old value
            if (reg_addr == REG_LEN && reg_wdata >= {LEN_PAD, LEN_MIN}
                    && reg_wdata <= {LEN_PAD, LEN_MAX}) begin
                len_r <= reg_wdata[LW-1:0];
            end
            if (reg_addr == REG_BASE) begin
                base_r <= reg_wdata;
            end
        end
    end

    // transfer sequencer, memory port and status
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_r <= S_IDLE;
            cnt_r <= '0;
            xlen_r <= LEN_RST;
            hdr_r <= 1'b0;
            word_r <= '0;
            hold_r <= '0;
            busy_r <= 1'b0;
            done_r <= 1'b0;
            err_r <= 1'b0;
            mem_addr_r <= '0;
            mem_wdata_r <= '0;
            mem_we_r <= 1'b0;
            mem_re_r <= 1'b0;
            rx_ready_r <= 1'b0;
        end else begin
            mem_we_r <= 1'b0;
            mem_re_r <= 1'b0;
            // rejected length write flags an error
            if (reg_wr && !busy_r && reg_addr == REG_LEN
                    && (reg_wdata < {LEN_PAD, LEN_MIN} || reg_wdata > {LEN_PAD, LEN_MAX})) begin
                err_r <= 1'b1;
            end
            unique case (state_r)
                S_IDLE: begin
                    if (start) begin
                        cnt_r <= '0;
                        xlen_r <= len_r;
                        busy_r <= 1'b1;
                        done_r <= 1'b0;
                        err_r <= 1'b0;
                        if (start_mode.rx) begin
                            rx_ready_r <= 1'b1;
                            state_r <= S_RX;
                        end else begin
                            // variable send reads length word first
                            hdr_r <= start_mode.var_len;
                            mem_re_r <= 1'b1;
                            mem_addr_r <= base_r;
                            state_r <= S_WT;
                        end
                    end
                end
                S_WT: begin
                    state_r <= S_CAP;
                end
                S_CAP: begin
                    if (hdr_r) begin
                        hdr_r <= 1'b0;
                        // length word in bytes, 1 up to maximum
                        if (mem_rdata != BASE_RST && mem_rdata <= {LEN_PAD, len_r}) begin
                            xlen_r <= mem_rdata[LW-1:0];
                            state_r <= S_RD;
                        end else begin
                            err_r <= 1'b1;
                            busy_r <= 1'b0;
                            state_r <= S_IDLE;
                        end
                    end else begin
                        word_r <= mem_rdata;
                        state_r <= S_TX0;
                    end
                end
                S_RD: begin
                    mem_re_r <= 1'b1;
                    mem_addr_r <= data_addr;
                    state_r <= S_WT;
                end
                S_TX0: begin
                    if (!skid_v_r) begin
                        cnt_r <= cnt_inc;
                        // odd last word sends only its first byte
                        if (last_b) begin
                            busy_r <= 1'b0;
                            done_r <= 1'b1;
                            state_r <= S_IDLE;
                        end else if (mode_r.low_only) begin
                            state_r <= S_RD;
                        end else begin
                            state_r <= S_TX1;
                        end
                    end
                end
                S_TX1: begin
                    if (!skid_v_r) begin
                        cnt_r <= cnt_inc;
                        if (last_b) begin
                            busy_r <= 1'b0;
                            done_r <= 1'b1;
                            state_r <= S_IDLE;
                        end else begin
                            state_r <= S_RD;
                        end
                    end
                end
                S_RX: begin
                    if (rx_take) begin
                        cnt_r <= cnt_inc;
                        if (!cnt_r[0]) begin
                            hold_r <= rx_byte.data;
                        end
                        // odd end writes the half-filled word
                        if (rx_full) begin
                            mem_we_r <= 1'b1;
                            mem_addr_r <= data_addr;
                            mem_wdata_r <= rx_word;
                        end
                        // extra bytes beyond the maximum are not accepted
                        if (rx_fin) begin
                            rx_ready_r <= 1'b0;
                            if (mode_r.var_len) begin
                                state_r <= S_LENWR;
                            end else begin
                                busy_r <= 1'b0;
                                done_r <= 1'b1;
                                state_r <= S_IDLE;
                            end
                        end
                    end
                end
                S_LENWR: begin
                    // received byte count into the base word
                    mem_we_r <= 1'b1;
                    mem_addr_r <= base_r;
                    mem_wdata_r <= {LEN_PAD, cnt_r};
                    busy_r <= 1'b0;
                    done_r <= 1'b1;
                    state_r <= S_IDLE;
                end
            endcase
        end
    end

    // two-entry skid buffer: a stalled receiver loses no byte
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            tx_byte_r <= '0;
            tx_valid_r <= 1'b0;
            skid_d_r <= '0;
            skid_v_r <= 1'b0;
        end else if (!tx_valid_r || tx_ready) begin
            if (skid_v_r) begin
                tx_byte_r <= skid_d_r;
                tx_valid_r <= 1'b1;
                skid_v_r <= 1'b0;
            end else begin
                tx_valid_r <= push_v;
                if (push_v) begin
                    tx_byte_r <= push_d;
                end
            end
        end else if (push_v) begin
            skid_d_r <= push_d;
            skid_v_r <= 1'b1;
        end
    end

    // register read port, data one cycle after the strobe
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rdata_r <= '0;
        end else if (reg_rd) begin
            unique case (reg_addr)
                REG_CTRL: rdata_r <= {11'h000, mode_r, 1'b0};
                REG_LEN: rdata_r <= {LEN_PAD, len_r};
                REG_BASE: rdata_r <= base_r;
                REG_STAT: rdata_r <= {13'h0000, err_r, done_r, busy_r};
                REG_CNT: rdata_r <= {LEN_PAD, cnt_r};
                default: rdata_r <= '0;
            endcase
        end
    end

    assign reg_rdata = rdata_r;
    assign mem_addr = mem_addr_r;
    assign mem_wdata = mem_wdata_r;
    assign mem_we = mem_we_r;
    assign mem_re = mem_re_r;
    assign tx_byte = tx_byte_r;
    assign tx_valid = tx_valid_r;
    assign rx_ready = rx_ready_r;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    // first fixed read
    property p_fixed_base;
        @(posedge ref_clk) disable iff (rst)
        $rose(busy_r) && !mode_r.rx && !mode_r.var_len |-> mem_re_r && mem_addr_r == base_r;
    endproperty
    a_fixed_base: assert property (p_fixed_base) else $error("fixed data not at base");

    property p_var_ofs;
        @(posedge ref_clk) disable iff (rst)
        (mem_re_r || mem_we_r) && mode_r.var_len && busy_r && !hdr_r && state_r != S_IDLE
            |-> mem_addr_r != base_r;
    endproperty
    a_var_ofs: assert property (p_var_ofs) else $error("variable data overlaps length");

    property p_odd_send;
        @(posedge ref_clk) disable iff (rst)
        push_v && state_r == S_TX0 && last_b |=> state_r == S_IDLE && done_r;
    endproperty
    a_odd_send: assert property (p_odd_send) else $error("extra byte after odd end");

    property p_zero_fill;
        @(posedge ref_clk) disable iff (rst)
        rx_take && rx_fin && !cnt_r[0] && !mode_r.low_only && !mode_r.swap
            |=> mem_we_r && mem_wdata_r[15:8] == ZERO_BYTE;
    endproperty
    a_zero_fill: assert property (p_zero_fill) else $error("odd word not zero filled");

    property p_low_store;
        @(posedge ref_clk) disable iff (rst)
        rx_take && mode_r.low_only |=> mem_we_r && mem_wdata_r[15:8] == ZERO_BYTE;
    endproperty
    a_low_store: assert property (p_low_store) else $error("upper byte not cleared");

    property p_order;
        @(posedge ref_clk) disable iff (rst)
        push_v && state_r == S_TX1 && !mode_r.swap |-> push_d.data == word_r[15:8];
    endproperty
    a_order: assert property (p_order) else $error("byte order wrong");

    property p_low_send;
        @(posedge ref_clk) disable iff (rst)
        push_v && mode_r.low_only |-> push_d.data == word_r[7:0] ##1 state_r != S_TX1;
    endproperty
    a_low_send: assert property (p_low_send) else $error("upper byte sent");

    property p_len_word;
        @(posedge ref_clk) disable iff (rst)
        state_r == S_LENWR |=> mem_we_r && mem_wdata_r == {LEN_PAD, $past(cnt_r)};
    endproperty
    a_len_word: assert property (p_len_word) else $error("length word not byte count");

    property p_len_range;
        @(posedge ref_clk) disable iff (rst)
        $rose(busy_r) |-> xlen_r >= LEN_MIN && xlen_r <= LEN_MAX;
    endproperty
    a_len_range: assert property (p_len_range) else $error("length out of range");

endmodule : bwp_packer

// File: sim/bwp_serial_peer.sv
// serial peer model: stalling byte sink and scripted byte source
module bwp_serial_peer
    import bwp_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire bwp_byte_t tx_byte,
    input wire logic tx_valid,
    output logic tx_ready,
    output bwp_byte_t rx_byte,
    output logic rx_valid,
    input wire logic rx_ready
);
    timeunit 1ns;
    timeprecision 1ps;

    bwp_byte_t got[$];
    bwp_byte_t src[0:15];
    int src_n = 0;
    int src_i = 0;
    logic [1:0] pace_r = 2'h0;

    // ---------------------------------------------------------------
    // sink
    // ---------------------------------------------------------------
    // stall one cycle in three so the two-entry buffer has to hold bytes
    always @(posedge ref_clk) begin
        pace_r <= (pace_r == 2'h2) ? 2'h0 : pace_r + 2'h1;
        tx_ready <= rst ? 1'b0 : (pace_r != 2'h0);
        if (tx_valid && tx_ready) begin
            got.push_back(tx_byte);
        end
    end

    // ---------------------------------------------------------------
    // source
    // ---------------------------------------------------------------
    // idle line shows the inverse of the last byte, never a stale copy
    always @(posedge ref_clk) begin
        if (rx_valid && rx_ready) begin
            src_i <= src_i + 1;
        end
    end
    assign rx_valid = (src_i < src_n);
    assign rx_byte = rx_valid ? src[src_i] : ~src[(src_i > 0) ? src_i - 1 : 0];

    // queue one byte; only called while the block is idle
    task automatic load(input logic [7:0] d, input logic lst);
        src[src_n] = {lst, d};
        src_n = src_n + 1;
    endtask : load

    task automatic clear();
        got.delete();
        src_n = 0;
        src_i = 0;
    endtask : clear
endmodule : bwp_serial_peer

// File: sim/byte_word_packet_packer_bench.sv
// self-checking bench for the byte/word packet packer
module byte_word_packet_packer_bench
    import bwp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [RAW-1:0] reg_addr = 4'h0;
    logic [DW-1:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [DW-1:0] reg_rdata;
    logic [DW-1:0] mem_addr;
    logic [DW-1:0] mem_wdata;
    logic mem_we;
    logic mem_re;
    logic [DW-1:0] rd_q = 16'h0000;
    bwp_byte_t tx_byte;
    logic tx_valid;
    logic tx_ready;
    bwp_byte_t rx_byte;
    logic rx_valid;
    logic rx_ready;
    logic [15:0] mem[0:63];
    logic [15:0] rv;
    int num_errors = 0;
    int checks = 0;
    int cycles = 0;

    bwp_packer uut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_we(mem_we), .mem_re(mem_re),
        .mem_rdata(rd_q), .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .rx_byte(rx_byte), .rx_valid(rx_valid), .rx_ready(rx_ready));

    bwp_serial_peer peer (.ref_clk(ref_clk), .rst(rst), .tx_byte(tx_byte),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_byte(rx_byte),
        .rx_valid(rx_valid), .rx_ready(rx_ready));

    initial begin
        forever #10 ref_clk = ~ref_clk;
    end

    // word store: read data stands from the cycle after the strobe to the next read
    always @(posedge ref_clk) begin
        if (mem_we) begin
            mem[mem_addr[5:0]] <= mem_wdata;
        end
        if (mem_re) begin
            rd_q <= mem[mem_addr[5:0]];
        end
    end

    // hang guard, well above the few hundred cycles the tests need
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors = num_errors + 1;
            summarize();
        end
    end

    // ---------------------------------------------------------------
    // access tasks
    // ---------------------------------------------------------------
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks = checks + 1;
        if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr

    // read data stands from the cycle after the strobe until the next read
    task automatic rd(input logic [3:0] a);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 rv = reg_rdata;
    endtask : rd

    // start a transfer, poll busy, then let the stall-delayed bytes drain
    task automatic run(input logic [3:0] mode, input logic [15:0] base, input logic [15:0] len);
        int n;
        wr(REG_BASE, base);
        wr(REG_LEN, len);
        wr(REG_CTRL, {11'h000, mode, 1'b1});
        n = 0;
        rv = 16'h0001;
        while (rv[ST_BUSY] !== 1'b0 && n < 400) begin
            rd(REG_STAT);
            n = n + 1;
        end
        chk("status", rv, 16'h0002);
        repeat (12) @(posedge ref_clk);
    endtask : run

    // one send case from base word 8 or 20, up to three expected bytes
    task automatic send(input logic [3:0] mode, input logic [15:0] base, input logic [15:0] len,
                        input int n, input logic [8:0] e0, input logic [8:0] e1,
                        input logic [8:0] e2);
        peer.clear();
        run(mode, base, len);
        chk("tx count", 16'(peer.got.size()), 16'(n));
        chk("tx byte0", {7'h00, peer.got[0]}, {7'h00, e0});
        chk("tx byte1", {7'h00, peer.got[1]}, {7'h00, e1});
        if (n > 2) begin
            chk("tx byte2", {7'h00, peer.got[2]}, {7'h00, e2});
        end
        $display("send test mode %h done", mode);
    endtask : send

    task automatic summarize();
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : summarize

    // ---------------------------------------------------------------
    // tests
    // ---------------------------------------------------------------
    initial begin
        for (int i = 0; i < 64; i++) begin
            mem[i] = 16'hFFFF;
        end
        mem[8] = 16'hB2A1;
        mem[9] = 16'hD4C3;
        mem[20] = 16'h0003;
        mem[21] = 16'hB2A1;
        mem[22] = 16'hD4C3;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        // reset values and an unmapped index
        rd(REG_LEN);
        chk("len reset", rv, {LEN_PAD, LEN_RST});
        rd(REG_BASE);
        chk("base reset", rv, BASE_RST);
        rd(REG_STAT);
        chk("stat reset", rv, 16'h0000);
        rd(4'hF);
        chk("unmapped", rv, 16'h0000);
        // lengths outside 1..2048 are refused, the upper bound 2048 accepted
        wr(REG_LEN, 16'h0000);
        rd(REG_STAT);
        chk("err flag", rv, 16'h0004);
        wr(REG_LEN, 16'h0801);
        rd(REG_LEN);
        chk("len kept", rv, 16'h0001);
        wr(REG_LEN, 16'h0800);
        rd(REG_LEN);
        chk("len max", rv, 16'h0800);
        $display("length limit test done");
        // send: plain odd, swapped odd, lower only, variable odd
        send(4'h0, 16'h0008, 16'h0003, 3, 9'h0A1, 9'h0B2, 9'h1C3);
        send(4'h8, 16'h0008, 16'h0003, 3, 9'h0B2, 9'h0A1, 9'h1D4);
        send(4'h4, 16'h0008, 16'h0002, 2, 9'h0A1, 9'h1C3, 9'h000);
        send(4'h2, 16'h0014, 16'h0004, 3, 9'h0A1, 9'h0B2, 9'h1C3);
        // fixed receive, odd length, two bytes per word
        peer.clear();
        peer.load(8'h11, 1'b0);
        peer.load(8'h22, 1'b0);
        peer.load(8'h33, 1'b1);
        run(4'h1, 16'h001E, 16'h0003);
        chk("rx w0", mem[30], 16'h2211);
        chk("rx w1", mem[31], 16'h0033);
        chk("rx w2", mem[32], 16'hFFFF);
        rd(REG_CNT);
        chk("rx count", rv, 16'h0003);
        $display("fixed receive test done");
        // variable receive ended early by the last flag
        peer.clear();
        for (int i = 1; i <= 5; i++) begin
            peer.load(8'(i), i == 5);
        end
        run(4'h3, 16'h0028, 16'h0008);
        chk("vrx len", mem[40], 16'h0005);
        chk("vrx w0", mem[41], 16'h0201);
        chk("vrx w1", mem[42], 16'h0403);
        chk("vrx w2", mem[43], 16'h0005);
        chk("vrx w3", mem[44], 16'hFFFF);
        $display("variable receive test done");
        // variable receive, lower bytes only
        peer.clear();
        peer.load(8'hAA, 1'b0);
        peer.load(8'hBB, 1'b1);
        run(4'h7, 16'h0032, 16'h0008);
        chk("lrx len", mem[50], 16'h0002);
        chk("lrx w0", mem[51], 16'h00AA);
        chk("lrx w1", mem[52], 16'h00BB);
        chk("lrx w2", mem[53], 16'hFFFF);
        $display("lower byte receive test done");
        summarize();
    end
endmodule : byte_word_packet_packer_bench
